// file: codec_pkg.sv
// constants shared by the codec serial port control block
package codec_pkg;
    // ======================================
    // register map (byte addresses)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADC    = 8'h18;
    localparam logic [7:0] OFF_DAC    = 8'h1c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int         NUM_CTRL   = 6;
    localparam logic [2:0] IDX_ADC    = 3'h6;

    // ======================================
    // control register fields
    localparam int MODE_BIT   = 0;
    localparam int MIXED_BIT  = 1;
    localparam int CASC_LSB   = 2;
    localparam int SWRST_BIT  = 7;
    localparam int SR_LSB     = 0;
    localparam int SCD_LSB    = 2;
    localparam int MCD_LSB    = 4;
    localparam int REF_EN_BIT = 6;
    localparam int GAIN_LSB   = 4;
    localparam int MUTE_BIT   = 7;
    localparam int BYPASS_BIT = 5;

    // ======================================
    // serial frame fields
    localparam int FLAG_BIT = 15;
    localparam int RW_BIT   = 14;
    localparam int DEV_LSB  = 11;
    localparam int REG_LSB  = 8;

    // ======================================
    // divider and timing counts
    localparam logic [2:0]  MDIV_MAX_CODE   = 3'h4;
    localparam logic [3:0]  SCLK_DIV_MAX    = 4'h8;
    localparam logic [10:0] PERIOD_MAX_LAST = 11'h7ff;
    localparam logic [2:0]  INTERP_LAST     = 3'h7;
    localparam logic [4:0]  SHIFT_MAX       = 5'h10;
    localparam logic [2:0]  RESET_DM_CYCLES = 3'h4;
    localparam int          GAIN_FRAC       = 12;
    localparam logic [2:0]  GAIN_UNITY_CODE = 3'h2;

    typedef enum logic {SP_IDLE, SP_SHIFT} port_state_e;
endpackage : codec_pkg

// file: codec_serial_port_control.sv
// codec serial port, control registers, clock dividers and interpolator
// Functional notes
// - input sample sent as 15 bits plus flag
// - output samples are two's complement full scale
// - interpolator upsamples from rate/M to rate/8
// - third-order comb filter, length 32 to 256
// - no new output sample: previous one reused
// - bypass bit routes samples around interpolator
// - gain field selects -15 to +6 dB
// - mute bit silences the analog output
// - reference bit enables buffered reference pin
// - serial words shifted msb first
// - only the codec starts a transfer
// - up to eight cascaded codecs supported
// - mode bit clear: frames access control registers
// - data mode: frames carry only samples
// - mixed mode: msb flags control or data
// - one shared register, reloaded each sample event when mode bit set
// - internal clock is pin clock divided 2,4,6,8,10 (master divider 1-5, then halved)
// - serial clock is internal clock /1,2,4,8
// - serial control writes land on falling edge
// - six 8-bit control and two sample registers
// - serial divider code 00 is divide by 8
// - sample divider code 00 is divide by 2048
// - master divider codes above 100 divide by 1
// - reset zeroes control, lasts four internal cycles
module codec_serial_port_control
    import codec_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sdi,
    input  wire logic [15:0] adc_sample,
    output logic             sclk,
    output logic             sdofs,
    output logic             sdo,
    output logic      [15:0] dac_sample,
    output logic             analog_out_mute,
    output logic             reference_out_enable
);

    // ======================================
    // decoding helpers
    function automatic logic [2:0] mdiv_last(input logic [2:0] code);
        return (code <= MDIV_MAX_CODE) ? code : 3'h0;
    endfunction : mdiv_last

    function automatic logic signed [14:0] gain_q(input logic [2:0] code);
        logic signed [14:0] g;
        g = 15'sd4096;
        unique case (code)
            3'h0: g = 15'sd8170;
            3'h1: g = 15'sd5786;
            3'h2: g = 15'sd4096;
            3'h3: g = 15'sd2900;
            3'h4: g = 15'sd2053;
            3'h5: g = 15'sd1453;
            3'h6: g = 15'sd1029;
            3'h7: g = 15'sd728;
        endcase
        return g;
    endfunction : gain_q

    // ======================================
    // storage and shared signals
    logic        [7:0]  ctrl [NUM_CTRL];
    logic        [15:0] shreg;
    logic        [15:0] adc_word;
    logic        [15:0] dac_hold;
    logic        [15:0] x_held;
    logic        [2:0]  half_cnt;
    logic               dm_phase;
    logic        [10:0] dm_cnt;
    logic        [3:0]  sc_cnt;
    logic        [7:0]  bits_left;
    logic        [2:0]  rst_cnt;
    logic               sdi_m;
    logic               sdi_s;
    port_state_e        state;

    logic        [1:0]  sr_code;
    logic        [1:0]  scd_code;
    logic        [2:0]  mcd_code;
    logic               half_tick;
    logic               dm_tick;
    logic               tick8;
    logic               sample_event;
    logic               sclk_toggle;
    logic        [15:0] next_word;
    logic               frame_end;
    logic               is_ctrl;
    logic               is_data;
    logic               ser_wr;
    logic               ser_rd;
    logic        [2:0]  ser_reg;
    logic        [2:0]  idx;
    logic               hit;
    logic               apb_wr;
    logic               rst_req;
    logic        [31:0] rd_val;

    assign sr_code  = ctrl[1][SR_LSB +: 2];
    assign scd_code = ctrl[1][SCD_LSB +: 2];
    assign mcd_code = ctrl[1][MCD_LSB +: 3];

    // ======================================
    // clock dividers
    assign half_tick    = (half_cnt == mdiv_last(mcd_code));
    assign dm_tick      = half_tick && dm_phase;
    assign tick8        = dm_tick && (dm_cnt[2:0] == INTERP_LAST);
    assign sample_event = dm_tick && (dm_cnt == (PERIOD_MAX_LAST >> sr_code));
    assign sclk_toggle  = half_tick && (sc_cnt == (SCLK_DIV_MAX >> scd_code) - 4'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt <= 3'h0;
            dm_phase <= 1'b0;
        end else if (half_tick) begin
            half_cnt <= 3'h0;
            dm_phase <= !dm_phase;
        end else begin
            half_cnt <= half_cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dm_cnt <= 11'h000;
        end else if (sample_event) begin
            dm_cnt <= 11'h000;
        end else if (dm_tick) begin
            dm_cnt <= dm_cnt + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_cnt <= 4'h0;
        end else if (sample_event || sclk_toggle) begin
            sc_cnt <= 4'h0;
        end else if (half_tick) begin
            sc_cnt <= sc_cnt + 4'h1;
        end
    end

    // ======================================
    // serial input synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
        end else begin
            sdi_m <= sdi;
            sdi_s <= sdi_m;
        end
    end

    // ======================================
    // frame decode
    assign next_word = {shreg[14:0], sdi_s};
    assign frame_end = (state == SP_SHIFT) && sclk_toggle && sclk && (bits_left == 8'h01);
    assign is_ctrl   = ctrl[0][MODE_BIT] ? (ctrl[0][MIXED_BIT] && next_word[FLAG_BIT])
                                         : next_word[FLAG_BIT];
    assign is_data   = ctrl[0][MODE_BIT] && !(ctrl[0][MIXED_BIT] && next_word[FLAG_BIT]);
    assign ser_reg   = next_word[REG_LSB +: 3];
    assign ser_wr    = frame_end && is_ctrl && !next_word[RW_BIT]
                       && (next_word[DEV_LSB +: 3] == 3'h0);
    assign ser_rd    = frame_end && is_ctrl && next_word[RW_BIT]
                       && (next_word[DEV_LSB +: 3] == 3'h0);

    // ======================================
    // serial port sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= SP_IDLE;
            shreg     <= 16'h0000;
            bits_left <= 8'h00;
            sclk      <= 1'b0;
            sdofs     <= 1'b0;
            sdo       <= 1'b0;
        end else if (sample_event) begin
            state     <= SP_SHIFT;
            bits_left <= {4'(ctrl[0][CASC_LSB +: 3]) + 4'h1, 4'h0};
            sclk      <= 1'b0;
            sdofs     <= 1'b1;
            if (ctrl[0][MODE_BIT]) begin
                shreg <= {1'b0, adc_sample[15:1]};
            end
        end else if (state == SP_SHIFT && sclk_toggle) begin
            if (!sclk) begin
                sclk <= 1'b1;
                sdo  <= shreg[15];
            end else begin
                sclk      <= 1'b0;
                sdofs     <= 1'b0;
                bits_left <= bits_left - 8'h01;
                if (ser_rd && ser_reg < 3'(NUM_CTRL)) begin
                    shreg <= {next_word[15:8], ctrl[ser_reg]};
                end else begin
                    shreg <= next_word;
                end
                if (bits_left == 8'h01) begin
                    state <= SP_IDLE;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_word <= 16'h0000;
        end else if (sample_event) begin
            adc_word <= {1'b0, adc_sample[15:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_hold <= 16'h0000;
        end else if (frame_end && is_data) begin
            dac_hold <= ctrl[0][MIXED_BIT] ? {next_word[14:0], 1'b0} : next_word;
        end
    end

    // ======================================
    // control registers and reset
    assign rst_req = (apb_wr && idx == 3'h0 && pwdata[SWRST_BIT])
                     || (ser_wr && ser_reg == 3'h0 && next_word[SWRST_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= 3'h0;
        end else if (rst_req) begin
            rst_cnt <= RESET_DM_CYCLES;
        end else if (dm_tick && rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end

    for (genvar i = 0; i < NUM_CTRL; i++) begin : g_ctrl
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl[i] <= CTRL_RESET;
            end else if (rst_cnt != 3'h0) begin
                ctrl[i] <= CTRL_RESET;
            end else if (apb_wr && idx == 3'(i)) begin
                ctrl[i] <= pwdata[7:0];
            end else if (ser_wr && ser_reg == 3'(i)) begin
                ctrl[i] <= next_word[7:0];
            end
        end
    end

    // ======================================
    // apb slave
    assign idx    = paddr[4:2];
    assign hit    = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    assign apb_wr = psel && penable && pready && pwrite && hit && (idx < 3'(NUM_CTRL));

    always_comb begin
        if (idx < 3'(NUM_CTRL)) begin
            rd_val = {24'h000000, ctrl[idx]};
        end else if (idx == IDX_ADC) begin
            rd_val = {16'h0000, adc_word};
        end else begin
            rd_val = {16'h0000, dac_hold};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata  <= hit ? rd_val : 32'h00000000;
                pslverr <= !hit;
            end
        end
    end

    // ======================================
    // interpolator
    logic signed [39:0] dly  [3];
    logic signed [39:0] cmb  [4];
    logic signed [39:0] c_out;
    logic signed [39:0] integ [3];
    logic               pend;
    logic        [4:0]  shamt;
    logic signed [39:0] scaled;
    logic signed [16:0] src;
    logic signed [31:0] prod;
    logic signed [31:0] lvl;

    assign cmb[0] = 40'(signed'(dac_hold));
    for (genvar k = 0; k < 3; k++) begin : g_comb
        assign cmb[k+1] = cmb[k] - dly[k];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dly[k] <= 40'sh0;
            end else if (sample_event) begin
                dly[k] <= cmb[k];
            end
        end
        if (k == 0) begin : g_first
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    integ[k] <= 40'sh0;
                end else if (tick8) begin
                    integ[k] <= integ[k] + (pend ? c_out : 40'sh0);
                end
            end
        end else begin : g_next
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    integ[k] <= 40'sh0;
                end else if (tick8) begin
                    integ[k] <= integ[k] + integ[k-1];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_out  <= 40'sh0;
            x_held <= 16'h0000;
            pend   <= 1'b0;
        end else if (sample_event) begin
            c_out  <= cmb[3];
            x_held <= dac_hold;
            pend   <= 1'b1;
        end else if (tick8) begin
            pend   <= 1'b0;
        end
    end

    assign shamt  = SHIFT_MAX - 5'(2 * sr_code);
    assign scaled = integ[2] >>> shamt;
    assign src    = ctrl[4][BYPASS_BIT] ? 17'(signed'(x_held)) : scaled[16:0];
    assign prod   = 32'(src) * 32'(gain_q(ctrl[3][GAIN_LSB +: 3]));
    assign lvl    = prod >>> GAIN_FRAC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_sample <= 16'h0000;
        end else if (tick8) begin
            if (ctrl[3][MUTE_BIT]) begin
                dac_sample <= 16'h0000;
            end else if (lvl > 32'sd32767) begin
                dac_sample <= 16'h7fff;
            end else if (lvl < -32'sd32768) begin
                dac_sample <= 16'h8000;
            end else begin
                dac_sample <= lvl[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_out_mute      <= 1'b0;
            reference_out_enable <= 1'b0;
        end else begin
            analog_out_mute      <= ctrl[3][MUTE_BIT];
            reference_out_enable <= ctrl[2][REF_EN_BIT];
        end
    end

    // ======================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [2:0] rst_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen <= 3'h0;
        end else if (rst_req) begin
            rst_seen <= 3'h0;
        end else if (dm_tick && rst_cnt != 3'h0) begin
            rst_seen <= rst_seen + 3'h1;
        end
    end

    sequence s_div_two;
        !half_tick ##1 half_tick;
    endsequence

    sequence s_first_bit;
        sdofs && !sclk;
    endsequence

    adc_flag_a: assert property (sample_event && ctrl[0][MODE_BIT] |=>
        ((shreg == {1'b0, $past(adc_sample[15:1])}) and s_first_bit))
        else $error("input word not flagged 15-bit sample");
    hold_prev_a: assert property (sample_event |=> x_held == $past(dac_hold))
        else $error("held output sample not reused");
    bypass_path_a: assert property (tick8 && ctrl[4][BYPASS_BIT] && !ctrl[3][MUTE_BIT]
        && ctrl[3][GAIN_LSB +: 3] == GAIN_UNITY_CODE |=> dac_sample == $past(x_held))
        else $error("bypass did not pass sample");
    mute_out_a: assert property (tick8 && ctrl[3][MUTE_BIT] |=>
        dac_sample == 16'h0000 && analog_out_mute)
        else $error("mute did not silence output");
    ref_enable_a: assert property ($rose(ctrl[2][REF_EN_BIT]) |=> reference_out_enable)
        else $error("reference pin not enabled");
    msb_first_a: assert property ($rose(sclk) |-> sdo == $past(shreg[15]))
        else $error("serial bit not msb first");
    data_mode_a: assert property (frame_end && ctrl[0][MODE_BIT] && !ctrl[0][MIXED_BIT]
        |=> dac_hold == $past(next_word))
        else $error("data frame did not update output sample");
    pgm_write_a: assert property (ser_wr && ser_reg == 3'h3 && rst_cnt == 3'h0 && !apb_wr
        |=> ctrl[3] == $past(next_word[7:0]) && !sclk)
        else $error("control frame write lost");
    div_two_a: assert property (half_tick && mcd_code == 3'h1 && !apb_wr && !ser_wr
        && rst_cnt == 3'h0
        |=> s_div_two)
        else $error("master divide by two wrong");
    sample_period_a: assert property (sample_event |->
        dm_cnt == (PERIOD_MAX_LAST >> sr_code) && dm_tick)
        else $error("sample period wrong");
    soft_reset_a: assert property ($fell(rst_cnt != 3'h0) |->
        rst_seen == RESET_DM_CYCLES && ctrl[1] == CTRL_RESET)
        else $error("soft reset not four internal cycles");

endmodule : codec_serial_port_control

// file: host_dsp_model.sv
// host serial port model driving and receiving codec frames
module host_dsp_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        sclk,
    input  wire logic        sdofs,
    input  wire logic        sdo,
    input  wire logic [15:0] tx_word,
    output logic             sdi,
    output logic      [15:0] rx_word,
    output logic      [7:0]  frames
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================
    // frame shifting
    logic        sclk_q;
    logic [2:0]  hold;
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q   <= 1'b0;
            hold     <= 3'h0;
            tx_cnt   <= 5'h10;
            rx_cnt   <= 5'h10;
            tx_shift <= 16'h0;
            rx_shift <= 16'h0;
            sdi      <= 1'b0;
            rx_word  <= 16'h0;
            frames   <= 8'h0;
        end else begin
            sclk_q <= sclk;
            if (sclk && !sclk_q && sdofs) begin
                sdi      <= tx_word[15];
                tx_shift <= {tx_word[14:0], 1'b0};
                tx_cnt   <= 5'h1;
                rx_cnt   <= 5'h0;
            end else if (sclk && !sclk_q && tx_cnt < 5'h10) begin
                sdi      <= tx_shift[15];
                tx_shift <= {tx_shift[14:0], 1'b0};
                tx_cnt   <= tx_cnt + 5'h1;
            end else if (rx_cnt == 5'h10 && hold == 3'h0) begin
                sdi <= ~sdi; // released line keeps no stale level
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
            if (!sclk && sclk_q && rx_cnt < 5'h10) begin
                rx_shift <= {rx_shift[14:0], sdo};
                rx_cnt   <= rx_cnt + 5'h1;
                if (rx_cnt == 5'hf) begin
                    rx_word <= {rx_shift[14:0], sdo};
                    frames  <= frames + 8'h1;
                    hold    <= 3'h7;
                end
            end
        end
    end
endmodule : host_dsp_model

// file: tb_codec_serial_port_control.sv
// self-checking bench for the codec serial port control block
module tb_codec_serial_port_control
    import codec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sdi;
    logic        sclk, sdofs, sdo, analog_out_mute, reference_out_enable, sdofs_q, sclk_q;
    logic [7:0]  paddr, frames;
    logic [31:0] pwdata, prdata, seed;
    logic [15:0] adc_sample, dac_sample, tx_word, rx_word;
    logic [7:0]  shadow [6];
    int          gap, last_gap, hi, last_hi, miscompares, samples_checked;
    // ======================================
    // design and host
    codec_serial_port_control u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sdi, .adc_sample, .sclk, .sdofs, .sdo, .dac_sample, .analog_out_mute,
        .reference_out_enable
    );
    host_dsp_model u_host (
        .pclk, .presetn, .sclk, .sdofs, .sdo, .tx_word, .sdi, .rx_word, .frames
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ======================================
    // frame and serial clock timing monitor
    always @(posedge pclk) begin
        sdofs_q <= sdofs;
        sclk_q  <= sclk;
        gap     <= (sdofs && !sdofs_q) ? 1 : gap + 1;
        hi      <= sclk ? hi + 1 : 0;
        if (sdofs && !sdofs_q) last_gap <= gap;
        if (!sclk && sclk_q) last_hi <= hi;
    end
    // ======================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask : rd
    task automatic wait_frames(input int n);
        logic [7:0] f;
        repeat (n) begin
            f = frames;
            while (frames === f) @(posedge pclk);
        end
    endtask : wait_frames
    task automatic send(input logic [15:0] w);
        tx_word <= w;
        wait_frames(2);
        tx_word <= 16'hb800;
        repeat (20) @(posedge pclk);
    endtask : send
    task automatic rate(input logic [7:0] v, input int per, input int h);
        wr(8'h04, {24'h0, v});
        wait_frames(3);
        chk(last_gap, per);
        chk(last_hi, h);
    endtask : rate
    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done
    task automatic results;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // ======================================
    // watchdog
    initial begin
        #990us;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
    // ======================================
    // tests
    initial begin
        int          dv;
        real         want;
        logic [15:0] a;
        logic [15:0] w;
        logic [7:0]  v;
        logic [2:0]  k;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        adc_sample = 16'h0;
        tx_word = 16'hb800;
        seed = 32'h0e2d9f76;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            shadow[i] = 8'h0;
            rd(8'(4 * i), 32'h0, 1'b0);
        end
        rd(8'h20, 32'h0, 1'b1);
        rd(8'h05, 32'h0, 1'b1);
        wr(OFF_DAC, 32'h1234);
        rd(OFF_DAC, 32'h0, 1'b0);
        done("map");
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            k = 3'h2 + {1'b0, seed[1:0]};
            v = seed[15:8];
            shadow[k] = v;
            wr(8'(4 * k), {24'h0, v});
            rd(8'(4 * k), {24'h0, v}, 1'b0);
            chk({31'h0, analog_out_mute}, {31'h0, shadow[3][7]});
            chk({31'h0, reference_out_enable}, {31'h0, shadow[2][6]});
        end
        done("registers");
        wr(8'h0c, 32'h80);
        wr(OFF_CTRL, 32'h80);
        repeat (20) @(posedge pclk);
        rd(8'h0c, 32'h0, 1'b0);
        rd(OFF_CTRL, 32'h0, 1'b0);
        chk({31'h0, analog_out_mute}, 32'h0);
        done("soft reset");
        wr(8'h04, 32'h03);
        seed = xs(seed);
        v = {1'b1, seed[6:0]};
        send({8'h83, v});
        rd(8'h0c, {24'h0, v}, 1'b0);
        chk({31'h0, analog_out_mute}, 32'h1);
        send(16'h8b00);
        rd(8'h0c, {24'h0, v}, 1'b0);
        wr(8'h08, {24'h0, seed[23:16]});
        send(16'hc200);
        wait_frames(1);
        chk({24'h0, rx_word[7:0]}, {24'h0, seed[23:16]});
        done("program mode");
        seed = xs(seed);
        a = seed[15:0];
        w = seed[31:16];
        adc_sample <= a;
        tx_word <= w;
        wr(OFF_CTRL, 32'h1);
        wait_frames(3);
        chk({16'h0, rx_word}, {17'h0, a[15:1]});
        rd(OFF_ADC, {17'h0, a[15:1]}, 1'b0);
        rd(OFF_DAC, {16'h0, w}, 1'b0);
        wr(8'h10, 32'h20);
        wr(8'h0c, 32'h20);
        wait_frames(2);
        repeat (40) @(posedge pclk);
        chk({16'h0, dac_sample}, {16'h0, w});
        tx_word <= 16'h0100;
        wait_frames(2);
        for (int c = 0; c < 8; c++) begin
            wr(8'h0c, {25'h0, 3'(c), 4'h0});
            repeat (40) @(posedge pclk);
            want = 256.0 * 10.0 ** ((6.0 - 3.0 * c) / 20.0);
            dv = $signed(dac_sample);
            samples_checked++;
            if ($isunknown(dac_sample) || dv > want + 4.0 || dv < want - 4.0) begin
                miscompares++;
                $display("unexpected at %0t: gain code %0d gave %0d", $time, c, dv);
            end
        end
        wr(8'h10, 32'h0);
        wr(8'h0c, 32'h20);
        tx_word <= w;
        wait_frames(6);
        chk({16'h0, dac_sample}, {16'h0, w});
        done("data mode");
        tx_word <= 16'hb800;
        wait_frames(2);
        wr(OFF_CTRL, 32'h3);
        seed = xs(seed);
        w = {1'b0, seed[14:0]};
        send(w);
        rd(OFF_DAC, {16'h0, w[14:0], 1'b0}, 1'b0);
        wait_frames(2);
        rd(OFF_DAC, {16'h0, w[14:0], 1'b0}, 1'b0);
        send(16'h8380);
        rd(8'h0c, 32'h80, 1'b0);
        chk({31'h0, analog_out_mute}, 32'h1);
        done("mixed mode");
        for (int c = 0; c < 4; c++) begin
            rate(8'(c), (2048 >> c) * 2, 8);
        end
        for (int m = 0; m < 8; m++) begin
            dv = (m < 5) ? m + 1 : 1;
            rate({1'b0, 3'(m), 4'h3}, 512 * dv, 8 * dv);
        end
        for (int s = 0; s < 4; s++) begin
            rate({4'h0, 2'(s), 2'h3}, 512, 8 >> s);
        end
        done("clock rates");
        results();
    end
endmodule : tb_codec_serial_port_control
